// >>> gpm_pkg.sv
// package of register map, field layout and codes for the pin source mux
package gpm_pkg;
    // sizes
    localparam int NPIN = 4;
    localparam int NA = 7;
    localparam int NEV = 10;
    localparam int FNW = 9;
    localparam int IDXW = 12;
    localparam int NSRC = 4;
    // register indices, byte address is four times the index
    localparam logic [IDXW-1:0] IDX_ML_CLK = 12'h18a;
    localparam logic [IDXW-1:0] IDX_OC = 12'h149;
    localparam logic [IDXW-1:0] IDX_AO_CLK = 12'h1ea;
    localparam logic [IDXW-1:0] IDX_SW = 12'h2c8;
    localparam logic [IDXW-1:0] IDX_PINFN = 12'h400;
    localparam logic [IDXW-1:0] IDX_EVT = 12'h404;
    localparam logic [IDXW-1:0] IDX_RAW = 12'h405;
    // field positions
    localparam int LP_EN_BIT = 0;
    localparam int LP_DIV_LSB = 1;
    localparam int OC_SEL_LSB = 0;
    localparam int OC_DIV_LSB = 3;
    localparam int OC_EN_BIT = 15;
    localparam int SW_LSB = 0;
    // reset values
    localparam logic [6:0] ML_DIV_RST = 7'h02;
    localparam logic [6:0] AO_DIV_RST = 7'h01;
    // synchronised input positions
    localparam int A_MLOCK = 0;
    localparam int A_AOLOCK = 1;
    localparam int A_SHORT = 2;
    localparam int A_SDDONE = 3;
    localparam int A_OTSD = 4;
    localparam int A_OTWARN = 5;
    localparam int A_CLAMP = 6;
    // event flag positions beyond the synchronised ones
    localparam int EV_TIMER = 6;
    localparam int EV_EVLOG = 8;
    // pin function codes
    localparam logic [FNW-1:0] FN_ML_CLK = 9'h010;
    localparam logic [FNW-1:0] FN_AO_CLK = 9'h013;
    localparam logic [FNW-1:0] FN_ML_LOCK = 9'h018;
    localparam logic [FNW-1:0] FN_AO_LOCK = 9'h01b;
    localparam logic [FNW-1:0] FN_OC = 9'h040;
    localparam logic [FNW-1:0] FN_PWM1 = 9'h048;
    localparam logic [FNW-1:0] FN_PWM2 = 9'h049;
    localparam logic [FNW-1:0] FN_SPDIF = 9'h04c;
    localparam logic [FNW-1:0] FN_SHORT = 9'h0b6;
    localparam logic [FNW-1:0] FN_SDDONE = 9'h0e0;
    localparam logic [FNW-1:0] FN_OTSD = 9'h0e1;
    localparam logic [FNW-1:0] FN_OTWARN = 9'h0e2;
    localparam logic [FNW-1:0] FN_TMR1 = 9'h140;
    localparam logic [FNW-1:0] FN_TMR2 = 9'h141;
    localparam logic [FNW-1:0] FN_EVL1 = 9'h150;
    localparam logic [FNW-1:0] FN_EVL2 = 9'h151;
    // switch modes
    localparam logic [1:0] SW_OPEN = 2'h0;
    localparam logic [1:0] SW_CLOSED = 2'h1;
    localparam logic [1:0] SW_CLAMP_ON = 2'h2;
    localparam logic [1:0] SW_CLAMP_OFF = 2'h3;
endpackage

// >>> gpm_clkdiv.sv
// integer clock divider with glitch-free gating and near half duty
`timescale 1ns/1ps
module gpm_clkdiv
    import gpm_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic en,
    input wire logic tick,
    input wire logic [6:0] ratio,
    // divided output
    output logic clk_o
);
    typedef struct packed {
        logic [6:0] cnt;
        logic out;
    } gpm_div_t;

    gpm_div_t r;
    gpm_div_t n;
    logic [6:0] hi;

    // high phase is the upper half of the ratio, rounded up
    assign hi = {1'b0, ratio[6:1]} + {6'h00, ratio[0]};

    // next-state: count source ticks, output high while below hi
    always_comb begin
        n = r;
        if (!en) begin
            n.cnt = 7'h00;
            n.out = 1'b0;
        end else if (tick) begin
            if (ratio < 7'h02) begin
                n.out = ~r.out; // fastest rate for ratio 0 and 1
            end else begin
                n.cnt = (r.cnt >= ratio - 7'h01) ? 7'h00 : r.cnt + 7'h01;
                n.out = (r.cnt < hi);
            end
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign clk_o = r.out;

    property p_div_off;
        @(posedge hclk) disable iff (!hresetn)
        !en |=> (!clk_o && r.cnt == 7'h00);
    endproperty
    a_div_off: assert property (p_div_off)
        else $error("divided clock not held low while disabled");
endmodule

// >>> gpm_pinmux.sv
// auxiliary pin sources: clock outputs, status routing, flags, switch
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - always-on loop divider bits 7:1; codes 0 and 1 divide by two.
// - main loop pin clock gated by enable bit 0, reset disabled.
// - always-on loop pin clock gated by enable bit 0, reset disabled.
// - codes 0x018 and 0x01b put loop lock levels on the pin.
// - loop lock rising edge sets a flag latched until cleared.
// - code 0x040 routes output clock; runs only with enable bit 15.
// - output clock divider bits 7:3, reset 0, codes 2 and up divide by value.
// - output clock source select bits 2:0 picks one of four sources.
// - codes 0x048 and 0x049 select the two pulse-width generators.
// - code 0x04c places the S/PDIF transmitter output on the pin.
// - codes 0x0b6, 0x0e0, 0x0e1, 0x0e2 show speaker and heat status.
// - overheat shutdown or speaker short disables the speaker outputs.
// - heat, short and shutdown status rising edges set latched flags.
// - codes 0x140 and 0x141 pulse high when a timer reaches final count.
// - each timer final count sets a latched flag.
// - codes 0x150 and 0x151 hold high while a logger FIFO is not empty.
// - each logger FIFO becoming not empty sets a latched flag.
// - switch mode 00 open, 01 closed, 10 clamp active, 11 clamp inactive.
// - main loop divider bits 7:1 reset 0x02, code N divides by N, codes 0 and 1 by two.
module gpm_pinmux
    import gpm_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // asynchronous status levels
    input wire logic main_loop_lock,
    input wire logic always_on_loop_lock,
    input wire logic spk_short,
    input wire logic spk_shutdown_done,
    input wire logic overheat_shutdown,
    input wire logic overheat_warning,
    input wire logic mic_detect_clamp,
    // same-clock sources
    input wire logic [NSRC-1:0] output_clock_src_tick,
    input wire logic [1:0] pwm_in,
    input wire logic spdif_in,
    input wire logic [1:0] timer_final,
    input wire logic [1:0] evlog_not_empty,
    // pins and status outputs
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe,
    output logic switch_closed,
    output logic spk_disable,
    output logic [NEV-1:0] event_flags
);
    typedef struct packed {
        logic [6:0] ml_div;
        logic ml_en;
        logic [6:0] ao_div;
        logic ao_en;
        logic oc_en;
        logic [4:0] oc_div;
        logic [2:0] oc_sel;
        logic [1:0] sw_mode;
        logic [NPIN*FNW-1:0] pin_fn;
        logic [NEV-1:0] flags;
        logic [NEV-1:0] prev;
        logic [NA-1:0] s1;
        logic [NA-1:0] s2;
        logic [NA-1:0] s3;
        logic [NA-1:0] filt;
        logic [NPIN-1:0] pout;
        logic [NPIN-1:0] poe;
        logic sw_closed;
        logic spk_off;
        logic dp_valid;
        logic dp_write;
        logic [IDXW-1:0] dp_idx;
        logic rd_done;
        logic [31:0] rdata;
    } gpm_state_t;

    gpm_state_t r;
    gpm_state_t n;
    logic [NA-1:0] async_in;
    logic [NEV-1:0] ev_raw;
    logic [NEV-1:0] ev_clr;
    logic [31:0] rd_val;
    logic wr_en;
    logic rd_wait;
    logic pfn_hit;
    logic [1:0] pidx;
    logic ml_clk;
    logic ao_clk;
    logic oc_clk;
    logic oc_tick;

    // gather asynchronous inputs for the three-stage synchroniser
    assign async_in = {mic_detect_clamp, overheat_warning, overheat_shutdown,
        spk_shutdown_done, spk_short, always_on_loop_lock, main_loop_lock};

    // raw event sources: filtered levels, timers, logger FIFOs
    assign ev_raw = {evlog_not_empty, timer_final, r.filt[A_OTWARN:0]};

    // data-phase decode
    assign wr_en = r.dp_valid & r.dp_write;
    assign rd_wait = r.dp_valid & ~r.dp_write & ~r.rd_done;
    assign pfn_hit = (r.dp_idx[IDXW-1:2] == IDX_PINFN[IDXW-1:2]);
    assign pidx = r.dp_idx[1:0];
    assign ev_clr = (wr_en && r.dp_idx == IDX_EVT) ? hwdata[NEV-1:0] : '0;

    // output clock source pick; reserved selects stop the clock
    assign oc_tick = (r.oc_sel < 3'h4) ? output_clock_src_tick[r.oc_sel[1:0]]
        : 1'b0;

    // read mux for the register in data phase
    always_comb begin
        rd_val = 32'h0000_0000;
        case (r.dp_idx)
            IDX_ML_CLK: begin
                rd_val[LP_DIV_LSB+:7] = r.ml_div;
                rd_val[LP_EN_BIT] = r.ml_en;
            end
            IDX_AO_CLK: begin
                rd_val[LP_DIV_LSB+:7] = r.ao_div;
                rd_val[LP_EN_BIT] = r.ao_en;
            end
            IDX_OC: begin
                rd_val[OC_EN_BIT] = r.oc_en;
                rd_val[OC_DIV_LSB+:5] = r.oc_div;
                rd_val[OC_SEL_LSB+:3] = r.oc_sel;
            end
            IDX_SW: rd_val[SW_LSB+:2] = r.sw_mode;
            IDX_EVT: rd_val[NEV-1:0] = r.flags;
            IDX_RAW: rd_val[NEV:0] = {r.filt[A_CLAMP], ev_raw};
            default: begin
                if (pfn_hit) begin
                    rd_val[FNW-1:0] = r.pin_fn[pidx*FNW+:FNW];
                end
            end
        endcase
    end

    // next-state logic for bus, registers, flags and pins
    always_comb begin
        n = r;
        // bus: writes finish at once, reads take one wait cycle
        if (rd_wait) begin
            n.rdata = rd_val;
            n.rd_done = 1'b1;
        end
        if (hready) begin
            n.dp_valid = hsel & htrans[1];
            n.dp_write = hwrite;
            n.dp_idx = haddr[IDXW+1:2];
            n.rd_done = 1'b0;
        end
        // register writes
        if (wr_en) begin
            case (r.dp_idx)
                IDX_ML_CLK: begin
                    n.ml_div = hwdata[LP_DIV_LSB+:7];
                    n.ml_en = hwdata[LP_EN_BIT];
                end
                IDX_AO_CLK: begin
                    n.ao_div = hwdata[LP_DIV_LSB+:7];
                    n.ao_en = hwdata[LP_EN_BIT];
                end
                IDX_OC: begin
                    n.oc_en = hwdata[OC_EN_BIT];
                    n.oc_div = hwdata[OC_DIV_LSB+:5];
                    n.oc_sel = hwdata[OC_SEL_LSB+:3];
                end
                IDX_SW: n.sw_mode = hwdata[SW_LSB+:2];
                default: begin
                    if (pfn_hit) begin
                        n.pin_fn[pidx*FNW+:FNW] = hwdata[FNW-1:0];
                    end
                end
            endcase
        end
        // three-stage synchroniser; a change counts once stages 2 and 3 agree
        n.s1 = async_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.filt = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.filt);
        // rising edges set sticky flags; a new event beats a clear
        n.prev = ev_raw;
        n.flags = (r.flags & ~ev_clr) | (ev_raw & ~r.prev);
        // speaker protection
        n.spk_off = r.filt[A_OTSD] | r.filt[A_SHORT];
        // analog switch control
        case (r.sw_mode)
            SW_OPEN: n.sw_closed = 1'b0;
            SW_CLOSED: n.sw_closed = 1'b1;
            SW_CLAMP_ON: n.sw_closed = r.filt[A_CLAMP];
            SW_CLAMP_OFF: n.sw_closed = ~r.filt[A_CLAMP];
            default: n.sw_closed = 1'b0;
        endcase
        // pin source selection per pin
        for (int i = 0; i < NPIN; i++) begin
            n.poe[i] = 1'b1;
            case (r.pin_fn[i*FNW+:FNW])
                FN_ML_CLK: n.pout[i] = ml_clk;
                FN_AO_CLK: n.pout[i] = ao_clk;
                FN_ML_LOCK: n.pout[i] = r.filt[A_MLOCK];
                FN_AO_LOCK: n.pout[i] = r.filt[A_AOLOCK];
                FN_OC: n.pout[i] = oc_clk;
                FN_PWM1: n.pout[i] = pwm_in[0];
                FN_PWM2: n.pout[i] = pwm_in[1];
                FN_SPDIF: n.pout[i] = spdif_in;
                FN_SHORT: n.pout[i] = r.filt[A_SHORT];
                FN_SDDONE: n.pout[i] = r.filt[A_SDDONE];
                FN_OTSD: n.pout[i] = r.filt[A_OTSD];
                FN_OTWARN: n.pout[i] = r.filt[A_OTWARN];
                FN_TMR1: n.pout[i] = timer_final[0];
                FN_TMR2: n.pout[i] = timer_final[1];
                FN_EVL1: n.pout[i] = evlog_not_empty[0];
                FN_EVL2: n.pout[i] = evlog_not_empty[1];
                default: begin
                    n.pout[i] = 1'b0;
                    n.poe[i] = 1'b0;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.ml_div <= ML_DIV_RST;
            r.ao_div <= AO_DIV_RST;
        end else begin
            r <= n;
        end
    end

    // main loop pin clock divider
    gpm_clkdiv u_ml_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .en(r.ml_en),
        .tick(1'b1),
        .ratio(r.ml_div),
        .clk_o(ml_clk)
    );

    // always-on loop pin clock divider
    gpm_clkdiv u_ao_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .en(r.ao_en),
        .tick(1'b1),
        .ratio(r.ao_div),
        .clk_o(ao_clk)
    );

    // output clock divider on the selected source ticks
    gpm_clkdiv u_oc_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .en(r.oc_en),
        .tick(oc_tick),
        .ratio({2'b00, r.oc_div}),
        .clk_o(oc_clk)
    );

    // outputs
    assign hreadyout = ~rd_wait;
    assign hrdata = r.rdata;
    assign hresp = 1'b0;
    assign pin_out = r.pout;
    assign pin_oe = r.poe;
    assign switch_closed = r.sw_closed;
    assign spk_disable = r.spk_off;
    assign event_flags = r.flags;

    // checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_ml_off;
        !r.ml_en ##1 !r.ml_en |-> !ml_clk;
    endproperty
    a_ml_off: assert property (p_ml_off)
        else $error("main loop pin clock runs while disabled");

    property p_ao_off;
        !r.ao_en |=> !ao_clk;
    endproperty
    a_ao_off: assert property (p_ao_off)
        else $error("always-on pin clock runs while disabled");

    property p_oc_off;
        !r.oc_en |=> !oc_clk;
    endproperty
    a_oc_off: assert property (p_oc_off)
        else $error("output clock runs while disabled");

    property p_lock_pin;
        (r.pin_fn[0+:FNW] == FN_ML_LOCK) |=>
            (pin_out[0] == $past(r.filt[A_MLOCK]) && pin_oe[0]);
    endproperty
    a_lock_pin: assert property (p_lock_pin)
        else $error("lock level not shown on pin 0");

    property p_lock_flag;
        $rose(r.filt[A_MLOCK]) |-> ##[1:2] r.flags[A_MLOCK];
    endproperty
    a_lock_flag: assert property (p_lock_flag)
        else $error("lock rise did not set its flag");

    property p_flag_hold;
        (r.flags[A_OTSD] && !ev_clr[A_OTSD]) |=> r.flags[A_OTSD];
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("shutdown flag dropped without a clear");

    property p_spk;
        r.filt[A_OTSD] || r.filt[A_SHORT] |=> spk_disable;
    endproperty
    a_spk: assert property (p_spk)
        else $error("speaker not disabled on fault");

    property p_timer_flag;
        (timer_final[0] && !r.prev[EV_TIMER]) |=> r.flags[EV_TIMER];
    endproperty
    a_timer_flag: assert property (p_timer_flag)
        else $error("timer final count did not set its flag");

    property p_evl_pin;
        (r.pin_fn[FNW+:FNW] == FN_EVL1) |=>
            (pin_out[1] == $past(evlog_not_empty[0]));
    endproperty
    a_evl_pin: assert property (p_evl_pin)
        else $error("logger not-empty level not shown on pin 1");

    property p_sw;
        (r.sw_mode == SW_CLAMP_OFF) |=> (switch_closed == !$past(r.filt[A_CLAMP]));
    endproperty
    a_sw: assert property (p_sw)
        else $error("switch does not follow inverted clamp");

    property p_rd_wait;
        rd_wait |-> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait state not exactly one cycle");
endmodule

// >>> gpm_far.sv
// far-side model: status levels, timer pulses and clock source ticks
`timescale 1ns/1ps
module gpm_far (
    // clock
    input wire logic hclk,
    // bench requests, one bit per far-side source
    input wire logic [13:0] want,
    // analog-side status levels
    output logic [6:0] async_lvl,
    // same-clock sources
    output logic [1:0] pwm,
    output logic spdif,
    output logic [1:0] evlog,
    output logic [1:0] timer,
    output logic [3:0] tick
);
    logic [2:0] cnt = 3'h0;
    logic [1:0] tm_q = 2'h0;
    // analog status moves off the clock grid, so it needs the synchroniser
    initial begin
        async_lvl = 7'h00;
        forever begin
            @(want[6:0]);
            async_lvl <= #7 want[6:0];
        end
    end
    // generator outputs follow the requests directly
    assign pwm = want[8:7];
    assign spdif = want[9];
    assign evlog = want[11:10];
    // a timer gives one single-cycle pulse per rising request edge
    always_ff @(posedge hclk) tm_q <= want[13:12];
    assign timer = want[13:12] & ~tm_q;
    // four source rates: every 1, 2, 4 and 8 cycles
    always_ff @(posedge hclk) cnt <= cnt + 3'h1;
    assign tick = {cnt == 3'h7, cnt[1:0] == 2'h3, cnt[0], 1'b1};
endmodule

// >>> gpio_aux_output_sources_tb.sv
// self-checking bench for the auxiliary pin source mux
`timescale 1ns/1ps
module gpio_aux_output_sources_tb
    import gpm_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [13:0] want = 14'h0;
    wire logic hready;
    logic hreadyout, hresp, spdif, switch_closed, spk_disable;
    logic [31:0] hrdata, rd;
    logic [6:0] alvl;
    logic [1:0] pwm, evlog, timer;
    logic [3:0] tick;
    logic [NPIN-1:0] pin_out, pin_oe;
    logic [NEV-1:0] event_flags;
    int mismatches = 0;
    int n_tests = 0;
    // the one slave's ready is the bus ready
    assign hready = hreadyout;
    gpm_pinmux gpm_pinmux_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .main_loop_lock(alvl[0]),
        .always_on_loop_lock(alvl[1]), .spk_short(alvl[2]),
        .spk_shutdown_done(alvl[3]), .overheat_shutdown(alvl[4]),
        .overheat_warning(alvl[5]), .mic_detect_clamp(alvl[6]),
        .output_clock_src_tick(tick), .pwm_in(pwm), .spdif_in(spdif),
        .timer_final(timer), .evlog_not_empty(evlog), .pin_out(pin_out),
        .pin_oe(pin_oe), .switch_closed(switch_closed),
        .spk_disable(spk_disable), .event_flags(event_flags));
    gpm_far gpm_far_i (.hclk(hclk), .want(want), .async_lvl(alvl),
        .pwm(pwm), .spdif(spdif), .evlog(evlog), .timer(timer),
        .tick(tick));
    // free-running bus clock, 40 ns period
    initial begin
        forever #20 hclk = ~hclk;
    end
    // counts, verdict and end of run
    task automatic conclude();
        $display("n_tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // compare seen with expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // wait for an edge with ready high, data taken at that edge
    task automatic wait_rdy(output logic [31:0] d);
        logic ok;
        ok = 1'b0;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(negedge hclk);
            ok = (hreadyout === 1'b1);
            d = hrdata;
            @(posedge hclk);
        end
        if (!ok) begin
            mismatches++;
            conclude();
        end
    endtask
    // one single word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [IDXW-1:0] idx,
            input logic [31:0] wd, output logic [31:0] d);
        logic [31:0] dummy;
        hsel <= 1'b1;
        haddr <= {18'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy(dummy);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy(d);
    endtask
    task automatic wr(input logic [IDXW-1:0] idx, input logic [31:0] wd);
        bus(1'b1, idx, wd, rd);
    endtask
    task automatic rdc(input logic [IDXW-1:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0, rd);
        chk(rd, exp);
        chk(32'(hresp), 32'h0);
    endtask
    // count high samples and rising edges of a pin over 24 cycles
    task automatic clkchk(input int p, input int ehi, input int ers);
        logic prev;
        int hi, rs;
        hi = 0;
        rs = 0;
        @(negedge hclk);
        prev = pin_out[p];
        repeat (24) begin
            @(negedge hclk);
            hi += int'(pin_out[p] === 1'b1);
            rs += int'(pin_out[p] === 1'b1 && prev === 1'b0);
            prev = pin_out[p];
        end
        @(posedge hclk);
        chk(32'(hi), 32'(ehi));
        chk(32'(rs), 32'(ers));
    endtask
    // reset values, reserved bits, unmapped index
    task automatic t_reset();
        rdc(IDX_ML_CLK, 32'h04);
        rdc(IDX_AO_CLK, 32'h02);
        rdc(IDX_OC, 32'h0);
        rdc(IDX_SW, 32'h0);
        wr(IDX_SW, 32'hffff_ffff);
        rdc(IDX_SW, 32'h3);
        wr(IDX_SW, 32'h0);
        wr(12'h123, 32'hffff_ffff);
        rdc(12'h123, 32'h0);
    endtask
    // rising edges latch flags until written with ones
    task automatic t_events();
        want[0] <= 1'b1;
        cyc(8);
        rdc(IDX_EVT, 32'h001);
        want[12] <= 1'b1;
        cyc(3);
        rdc(IDX_EVT, 32'h041);
        want <= 14'h1821;
        cyc(8);
        rdc(IDX_EVT, 32'h261);
        wr(IDX_EVT, 32'h041);
        rdc(IDX_EVT, 32'h220);
        want <= 14'h0;
        cyc(8);
        rdc(IDX_EVT, 32'h220);
        chk(32'(event_flags), 32'h220);
        wr(IDX_EVT, 32'h3ff);
    endtask
    // overheat shutdown or short turns the speaker off
    task automatic t_spk();
        for (int k = 2; k <= 4; k += 2) begin
            want[k] <= 1'b1;
            cyc(8);
            chk(32'(spk_disable), 32'h1);
            want[k] <= 1'b0;
            cyc(8);
            chk(32'(spk_disable), 32'h0);
        end
    endtask
    // every switch mode against both clamp levels
    task automatic t_switch();
        logic e;
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 2; c++) begin
                want[6] <= c[0];
                wr(IDX_SW, 32'(m));
                cyc(8);
                e = (m == 1) || (m == 2 && c == 1) || (m == 3 && c == 0);
                chk(32'(switch_closed), 32'(e));
            end
        end
        want[6] <= 1'b0;
    endtask
    // each level source on a pin, then an unknown code releases it
    task automatic t_route();
        logic [FNW-1:0] codes [11] = '{FN_ML_LOCK, FN_AO_LOCK, FN_SHORT,
            FN_SDDONE, FN_OTSD, FN_OTWARN, FN_PWM1, FN_PWM2, FN_SPDIF,
            FN_EVL1, FN_EVL2};
        int bits [11] = '{0, 1, 2, 3, 4, 5, 7, 8, 9, 10, 11};
        int p;
        for (int i = 0; i < 11; i++) begin
            p = i % NPIN;
            wr(IDX_PINFN + 12'(p), 32'(codes[i]));
            want[bits[i]] <= 1'b1;
            cyc(8);
            chk(32'({pin_oe[p], pin_out[p]}), 32'h3);
            want[bits[i]] <= 1'b0;
            cyc(8);
            chk(32'({pin_oe[p], pin_out[p]}), 32'h2);
            wr(IDX_PINFN + 12'(p), 32'h1ff);
            cyc(3);
            chk(32'(pin_oe[p]), 32'h0);
        end
        for (int t = 0; t < 2; t++) begin
            wr(IDX_PINFN, 32'(FN_TMR1) + 32'(t));
            want[12 + t] <= 1'b1;
            clkchk(0, 1, 1);
            want[12 + t] <= 1'b0;
            cyc(1);
        end
    endtask
    // divided pin clocks, gating and restart
    task automatic t_clocks();
        wr(IDX_PINFN, 32'(FN_ML_CLK));
        wr(IDX_ML_CLK, 32'h07);
        clkchk(0, 16, 8);
        wr(IDX_ML_CLK, 32'h06);
        cyc(2);
        clkchk(0, 0, 0);
        wr(IDX_ML_CLK, 32'h08);
        wr(IDX_ML_CLK, 32'h09);
        clkchk(0, 12, 6);
        wr(IDX_PINFN + 12'h1, 32'(FN_AO_CLK));
        wr(IDX_AO_CLK, 32'h01);
        clkchk(1, 12, 12);
        wr(IDX_AO_CLK, 32'h00);
        cyc(2);
        clkchk(1, 0, 0);
        wr(IDX_AO_CLK, 32'h0c);
        wr(IDX_AO_CLK, 32'h0d);
        clkchk(1, 12, 4);
        wr(IDX_PINFN + 12'h2, 32'(FN_OC));
        wr(IDX_OC, 32'h0021);
        clkchk(2, 0, 0);
        wr(IDX_OC, 32'h8021);
        rdc(IDX_OC, 32'h8021);
        clkchk(2, 12, 3);
        wr(IDX_OC, 32'h0021);
        wr(IDX_OC, 32'h0010);
        wr(IDX_OC, 32'h8010);
        clkchk(2, 12, 12);
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_events();
        t_spk();
        t_switch();
        t_route();
        t_clocks();
        conclude();
    end
endmodule
